// >>> hw/srl_latch_unit.sv
// Set/reset latch unit with a classic Wishbone register slave
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R01 - Enabled latch with true-output enable drives true output pin.
// R02 - Enabled latch with inverted-output enable drives inverted output pin.
// R03 - Both output pins may be driven at the same time.
// R04 - Software clears port direction of pins used for latch outputs.
// R05 - Latch state undefined after reset; software initialises before enabling.
// R06 - Latch enable bit gates the latch; disabled means pins undriven.
// R07 - Divider pulse one cycle wide, every 2^(code+2) cycles.
// R08 - Writing one to set pulse bit sets latch for one cycle.
// R09 - Writing one to reset pulse bit resets latch for one cycle.
// R10 - Pulse bits self-clear and always read zero.
// R11 - Pin set enable lets high input pin set the latch.
// R12 - Divider set enable lets periodic pulse set the latch.
// R13 - Comparator set enables let high comparator outputs set latch.
// R14 - Pin reset enable lets high input pin reset the latch.
// R15 - Divider reset enable lets periodic pulse reset the latch.
// R16 - Comparator reset enables let high comparator outputs reset latch.
// R17 - Reset dominates when set and reset are both high.
// R18 - Comparator inputs may be the timer-synchronised versions.
// R19 - Set and reset are ORs of all enabled sources.
module srl_latch_unit (
  input  wire logic        core_clk,               // System clock 250 MHz
  input  wire logic        reset,                  // Synchronous, high
  input  wire logic        wb_cyc_i,               // Bus cycle
  input  wire logic        wb_stb_i,               // Bus strobe
  input  wire logic        wb_we_i,                // Write enable
  input  wire logic [3:0]  wb_adr_i,               // Byte address
  input  wire logic [3:0]  wb_sel_i,               // Byte selects
  input  wire logic [31:0] wb_dat_i,               // Write data
  output logic      [31:0] wb_dat_o,               // Read data
  output logic             wb_ack_o,               // Acknowledge
  input  wire logic        latch_input_pin,        // External set/reset pin
  input  wire logic        cmp1_raw_output,        // Comparator 1 raw
  input  wire logic        cmp2_raw_output,        // Comparator 2 raw
  input  wire logic        cmp1_synced_output,     // Comparator 1 synced
  input  wire logic        cmp2_synced_output,     // Comparator 2 synced
  input  wire logic        cmp1_sync_select,       // Use synced cmp1
  input  wire logic        cmp2_sync_select,       // Use synced cmp2
  output logic             true_output_pin,        // Latch Q out
  output logic             true_output_pin_oe,     // Q driver enable
  output logic             inverted_output_pin,    // Latch inverted out
  output logic             inverted_output_pin_oe  // Inverted driver enable
);
  import srl_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0]               ctrl;      // pulse bits always stored as 0
    logic [7:0]               src;
    logic                     pset;      // one-cycle software set
    logic                     prst;      // one-cycle software reset
    logic [SRL_DIV_WIDTH-1:0] div_cnt;
    logic                     div_pulse;
    logic [2:0]               pin_sh;    // pin synchroniser
    logic [2:0]               c1_sh;
    logic [2:0]               c2_sh;
    logic                     pin_lvl;
    logic                     c1_lvl;
    logic                     c2_lvl;
    logic                     q;
    logic                     ack;
    logic [31:0]              rdata;
    logic                     q_pin;
    logic                     q_oe;
    logic                     nq_pin;
    logic                     nq_oe;
  } srl_state_type;

  srl_state_type state_reg;
  srl_state_type state_next;

  logic                     wr_hit;
  logic                     rd_ctrl;
  logic                     set_in;
  logic                     rst_in;
  logic                     q_new;
  logic [SRL_DIV_WIDTH-1:0] div_mask;
  logic                     c1_src;
  logic                     c2_src;

  // ==========================================================
  // Comparator source selection; both are treated as async
  assign c1_src = cmp1_sync_select ? cmp1_synced_output : cmp1_raw_output; // R18
  assign c2_src = cmp2_sync_select ? cmp2_synced_output : cmp2_raw_output; // R18

  // Divider mask: all ones below bit code+2
  assign div_mask = SRL_DIV_WIDTH'((10'h001 << (32'(state_reg.ctrl[6:4])
                    + SRL_DIV_BASE_LOG2)) - 10'h001); // R07

  // Combined latch inputs from every enabled source
  assign set_in = state_reg.pset
    | (state_reg.src[SRL_PIN_SET_BIT] & state_reg.pin_lvl)   // R11
    | (state_reg.src[SRL_DIV_SET_BIT] & state_reg.div_pulse) // R12
    | (state_reg.src[SRL_C2_SET_BIT]  & state_reg.c2_lvl)    // R13
    | (state_reg.src[SRL_C1_SET_BIT]  & state_reg.c1_lvl);   // R19
  assign rst_in = state_reg.prst
    | (state_reg.src[SRL_PIN_RST_BIT] & state_reg.pin_lvl)   // R14
    | (state_reg.src[SRL_DIV_RST_BIT] & state_reg.div_pulse) // R15
    | (state_reg.src[SRL_C2_RST_BIT]  & state_reg.c2_lvl)    // R16
    | (state_reg.src[SRL_C1_RST_BIT]  & state_reg.c1_lvl);   // R19

  // Reset dominant latch
  assign q_new = rst_in ? 1'b0 : (set_in ? 1'b1 : state_reg.q); // R17

  assign wr_hit  = wb_cyc_i & wb_stb_i & wb_we_i & ~state_reg.ack & wb_sel_i[0];
  assign rd_ctrl = (wb_adr_i == SRL_CTRL_OFFSET);

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    // Three-stage synchronisers; a change counts when stages 2 and 3 agree
    state_next.pin_sh = {state_reg.pin_sh[1:0], latch_input_pin};
    state_next.c1_sh  = {state_reg.c1_sh[1:0], c1_src};
    state_next.c2_sh  = {state_reg.c2_sh[1:0], c2_src};
    if (state_reg.pin_sh[2] == state_reg.pin_sh[1])
      state_next.pin_lvl = state_reg.pin_sh[2];
    if (state_reg.c1_sh[2] == state_reg.c1_sh[1])
      state_next.c1_lvl = state_reg.c1_sh[2];
    if (state_reg.c2_sh[2] == state_reg.c2_sh[1])
      state_next.c2_lvl = state_reg.c2_sh[2];
    // Free-running divider; pulse one cycle when low bits wrap
    state_next.div_cnt   = state_reg.div_cnt + 1'b1;
    state_next.div_pulse = ((state_reg.div_cnt & div_mask) == div_mask); // R07
    // Software pulses last one cycle only
    state_next.pset = 1'b0; // R08
    state_next.prst = 1'b0; // R09
    // Latch keeps updating from its sources while disabled, so it can be primed first
    state_next.q = q_new; // R05
    // Bus slave: one wait state, ack drops the cycle after it rises
    state_next.ack   = wb_cyc_i & wb_stb_i & ~state_reg.ack;
    state_next.rdata = 32'h0000_0000;
    if (wb_cyc_i & wb_stb_i & ~state_reg.ack & ~wb_we_i)
    begin
      if (rd_ctrl)
        state_next.rdata = {24'h000000, state_reg.ctrl[7:2], 2'b00}; // R10
      else if (wb_adr_i == SRL_SRC_OFFSET)
        state_next.rdata = {24'h000000, state_reg.src};
    end
    if (wr_hit & rd_ctrl)
    begin
      state_next.ctrl = {wb_dat_i[7:2], 2'b00}; // R10
      state_next.pset = wb_dat_i[SRL_PSET_BIT]; // R08
      state_next.prst = wb_dat_i[SRL_PRST_BIT]; // R09
    end
    if (wr_hit & (wb_adr_i == SRL_SRC_OFFSET))
      state_next.src = wb_dat_i[7:0];
    // Output pins; both may be live together
    state_next.q_pin  = state_reg.q;
    state_next.nq_pin = ~state_reg.q;
    state_next.q_oe   = state_reg.ctrl[SRL_LEN_BIT]
                        & state_reg.ctrl[SRL_QEN_BIT];  // R01
    state_next.nq_oe  = state_reg.ctrl[SRL_LEN_BIT]
                        & state_reg.ctrl[SRL_NQEN_BIT]; // R02
    if (reset)
    begin
      state_next       = '0;
      state_next.ctrl  = SRL_CTRL_RESET;
      state_next.src   = SRL_SRC_RESET;
      state_next.q     = state_reg.q; // latch not initialised by reset
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk)
  begin
    state_reg <= state_next;
  end

  assign wb_dat_o               = state_reg.rdata;
  assign wb_ack_o               = state_reg.ack;
  assign true_output_pin        = state_reg.q_pin;
  assign true_output_pin_oe     = state_reg.q_oe;      // R06
  assign inverted_output_pin    = state_reg.nq_pin;
  assign inverted_output_pin_oe = state_reg.nq_oe;     // R03

  // ==========================================================
  // Checks
  qen_follows_a: assert property (@(posedge core_clk) disable iff (reset)
    ##1 true_output_pin_oe == $past(state_reg.ctrl[7] & state_reg.ctrl[3]))
    else $error("true output enable wrong"); // R01
  nqen_follows_a: assert property (@(posedge core_clk) disable iff (reset)
    ##1 inverted_output_pin_oe == $past(state_reg.ctrl[7] & state_reg.ctrl[2]))
    else $error("inverted output enable wrong"); // R02
  disabled_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
    !state_reg.ctrl[7] |=> !true_output_pin_oe && !inverted_output_pin_oe)
    else $error("pins driven while disabled"); // R06
  pulse_once_a: assert property (@(posedge core_clk) disable iff (reset)
    state_reg.pset |=> !state_reg.pset)
    else $error("set pulse longer than one cycle"); // R08
  rpulse_once_a: assert property (@(posedge core_clk) disable iff (reset)
    state_reg.prst |=> !state_reg.prst)
    else $error("reset pulse longer than one cycle"); // R09
  pulse_bits_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    wb_ack_o |-> wb_dat_o[1:0] == 2'b00)
    else $error("pulse bits read nonzero"); // R10
  reset_dom_a: assert property (@(posedge core_clk) disable iff (reset)
    rst_in |=> !state_reg.q)
    else $error("latch not reset"); // R17
  set_works_a: assert property (@(posedge core_clk) disable iff (reset)
    set_in && !rst_in |=> state_reg.q)
    else $error("latch not set"); // R19
  div_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
    state_reg.div_pulse && state_reg.ctrl[6:4] == 3'h0
    && $stable(state_reg.ctrl) |=> !state_reg.div_pulse ##3 state_reg.div_pulse)
    else $error("divider period wrong"); // R07
  // Both drivers may be live at once when both enables are set
  both_pins_a: assert property (@(posedge core_clk) disable iff (reset)
    state_reg.ctrl[7] && state_reg.ctrl[3] && state_reg.ctrl[2]
    |=> true_output_pin_oe && inverted_output_pin_oe)
    else $error("both pins not driven together"); // R03
  // Only looked at while a pad is driven: the latch is unknown until primed
  inv_pins_a: assert property (@(posedge core_clk) disable iff (reset)
    true_output_pin_oe || inverted_output_pin_oe
    |-> inverted_output_pin == ~true_output_pin)
    else $error("outputs not complementary"); // R05
  q_pin_follows_a: assert property (@(posedge core_clk) disable iff (reset)
    ##1 true_output_pin_oe |-> true_output_pin == $past(state_reg.q))
    else $error("true pin does not follow latch"); // R01

  // ==========================================================
  // Bus checks
  ack_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (@(posedge core_clk) disable iff (reset)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  rdata_upper_a: assert property (@(posedge core_clk) disable iff (reset)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  ctrl_write_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_hit && rd_ctrl |=> state_reg.ctrl[1:0] == 2'b00)
    else $error("pulse bits stored"); // R10
  pset_write_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_hit && rd_ctrl && wb_dat_i[1] |=> state_reg.pset)
    else $error("set pulse not raised"); // R08

  // ==========================================================
  // Source checks
  div_narrow_a: assert property (@(posedge core_clk) disable iff (reset)
    state_reg.div_pulse |=> !state_reg.div_pulse)
    else $error("divider pulse wider than one cycle"); // R07
  pin_set_a: assert property (@(posedge core_clk) disable iff (reset)
    state_reg.src[7] && state_reg.pin_lvl && !rst_in |=> state_reg.q)
    else $error("pin did not set latch"); // R11
  pin_reset_a: assert property (@(posedge core_clk) disable iff (reset)
    state_reg.src[3] && state_reg.pin_lvl |=> !state_reg.q)
    else $error("pin did not reset latch"); // R14

endmodule
`default_nettype wire

// >>> hw/srl_pkg.sv
// Package of constants for the set/reset latch unit
package srl_pkg;

  // ==========================================================
  // Register map (word offsets on the bus, byte addresses)
  localparam logic [3:0] SRL_CTRL_OFFSET = 4'h0; // latch_control_primary
  localparam logic [3:0] SRL_SRC_OFFSET  = 4'h4; // latch_source_enables
  localparam logic [7:0] SRL_CTRL_RESET  = 8'h00;
  localparam logic [7:0] SRL_SRC_RESET   = 8'h00;

  // ==========================================================
  // Field positions in latch_control_primary
  localparam int SRL_LEN_BIT   = 7;
  localparam int SRL_DIV_LSB   = 4;
  localparam int SRL_QEN_BIT   = 3;
  localparam int SRL_NQEN_BIT  = 2;
  localparam int SRL_PSET_BIT  = 1;
  localparam int SRL_PRST_BIT  = 0;

  // ==========================================================
  // Field positions in latch_source_enables
  localparam int SRL_PIN_SET_BIT  = 7;
  localparam int SRL_DIV_SET_BIT  = 6;
  localparam int SRL_C2_SET_BIT   = 5;
  localparam int SRL_C1_SET_BIT   = 4;
  localparam int SRL_PIN_RST_BIT  = 3;
  localparam int SRL_DIV_RST_BIT  = 2;
  localparam int SRL_C2_RST_BIT   = 1;
  localparam int SRL_C1_RST_BIT   = 0;

  // ==========================================================
  // Divider: pulse every 2^(code+2) cycles, longest 512
  localparam int SRL_DIV_WIDTH     = 9;
  localparam int SRL_DIV_BASE_LOG2 = 2;

endpackage

// >>> verification/srl_far_side_model.sv
// Far-side model: comparators, latch input pin and output pads
`timescale 1ns/1ps
`default_nettype none

module srl_far_side_model (
  input  wire logic       core_clk, // System clock
  input  wire logic [4:0] lvl,      // Pin, c1 raw, c2 raw, c1 sync, c2 sync
  input  wire logic       q,        // Latch true output
  input  wire logic       q_oe,     // True driver enable
  input  wire logic       nq,       // Latch inverted output
  input  wire logic       nq_oe,    // Inverted driver enable
  output logic            pin,      // Latch input pin level
  output logic [3:0]      cmp,      // c1 raw, c2 raw, c1 sync, c2 sync
  output logic            pad_q,    // Level seen on the true pad
  output logic            pad_nq    // Level seen on the inverted pad
);
  logic last_q  = 1'b0;
  logic last_nq = 1'b0;

  // ==========================================================
  // Analog side levels, asynchronous to the core clock
  assign pin = lvl[4];
  assign cmp = lvl[3:0];

  // Remember the last driven value so a released pad never looks stale
  always_ff @(posedge core_clk)
  begin
    if (q_oe)
      last_q <= q;
    if (nq_oe)
      last_nq <= nq;
  end

  // Pad follows the driver only while enabled, else the inverse
  assign pad_q  = q_oe  ? q  : ~last_q;
  assign pad_nq = nq_oe ? nq : ~last_nq;
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
// Register-level testbench for the set/reset latch unit
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import srl_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [3:0]  wb_adr   = 4'h0;
  logic [3:0]  wb_sel   = 4'hf;
  logic [31:0] wb_wdat  = 32'h0;
  logic [31:0] wb_rdat;
  logic [31:0] rd;
  logic        wb_ack;
  logic [4:0]  lvl      = 5'h00;
  logic [1:0]  sync_sel = 2'h0;
  logic        pin, q, q_oe, nq, nq_oe, pad_q, pad_nq;
  logic [3:0]  cmp;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          n;
  // Source table: enables, levels, sync select, expected true pad
  logic [7:0]  src_t [12] = '{8'h80, 8'h88, 8'h10, 8'h08, 8'h20, 8'h01,
                              8'h40, 8'h02, 8'h20, 8'h00, 8'h80, 8'h04};
  logic [4:0]  lvl_t [12] = '{5'h10, 5'h10, 5'h08, 5'h10, 5'h01, 5'h02,
                              5'h00, 5'h01, 5'h04, 5'h1f, 5'h10, 5'h00};
  logic [1:0]  sel_t [12] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1,
                              2'h0, 2'h2, 2'h2, 2'h3, 2'h0, 2'h0};
  logic        exp_t [12] = '{1, 0, 1, 0, 1, 0, 1, 0, 0, 0, 1, 0};

  // ==========================================================
  // Clock, design and far side
  always #2 core_clk = ~core_clk;

  srl_latch_unit i_srl_latch_unit (.core_clk(core_clk), .reset(reset),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .latch_input_pin(pin),
    .cmp1_raw_output(cmp[3]), .cmp2_raw_output(cmp[2]),
    .cmp1_synced_output(cmp[1]), .cmp2_synced_output(cmp[0]),
    .cmp1_sync_select(sync_sel[0]), .cmp2_sync_select(sync_sel[1]),
    .true_output_pin(q), .true_output_pin_oe(q_oe),
    .inverted_output_pin(nq), .inverted_output_pin_oe(nq_oe));

  srl_far_side_model i_srl_far_side_model (.core_clk(core_clk), .lvl(lvl),
    .q(q), .q_oe(q_oe), .nq(nq), .nq_oe(nq_oe), .pin(pin), .cmp(cmp),
    .pad_q(pad_q), .pad_nq(pad_nq));

  // ==========================================================
  // Shared tasks
  task automatic results();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
    int t;
    @(posedge core_clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_wdat <= {24'h0, d};
    t = 0;
    do
    begin
      @(posedge core_clk);
      t++;
    end
    while (wb_ack !== 1'b1 && t < 50);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    check(t < 50, 1'b1);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    n += k;
  endtask

  // Waits for the true pad, bounded so a stuck latch cannot hang
  task automatic wait_q(input logic v);
    int t;
    for (t = 0; pad_q !== v && t < 1200; t++)
      tick(1);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    bus(0, SRL_CTRL_OFFSET, 8'h00);
    check(rd, SRL_CTRL_RESET);
    bus(0, SRL_SRC_OFFSET, 8'h00);
    check(rd, SRL_SRC_RESET);
    // A write without the low byte lane must be ignored
    wb_sel <= 4'he;
    bus(1, SRL_SRC_OFFSET, 8'hff);
    wb_sel <= 4'hf;
    bus(0, SRL_SRC_OFFSET, 8'h00);
    check(rd, SRL_SRC_RESET);
    bus(1, 4'h8, 8'hff);
    bus(0, 4'h8, 8'h00);
    check(rd, 32'h0);
    bus(1, SRL_CTRL_OFFSET, 8'h01);
    bus(1, SRL_CTRL_OFFSET, 8'h8e);
    bus(0, SRL_CTRL_OFFSET, 8'h00);
    check(rd, 32'h8c);
    tick(4);
    check({q_oe, nq_oe, pad_q, pad_nq}, 4'b1110);
    bus(1, SRL_CTRL_OFFSET, 8'h8d);
    tick(4);
    check({pad_q, pad_nq}, 2'b01);
    bus(1, SRL_CTRL_OFFSET, 8'h88);
    tick(2);
    check({q_oe, nq_oe}, 2'b10);
    bus(1, SRL_CTRL_OFFSET, 8'h0c);
    tick(2);
    check({q_oe, nq_oe}, 2'b00);
    bus(1, SRL_CTRL_OFFSET, 8'h8c);
    // Each source in turn, levels quiet while enables change
    for (int i = 0; i < 12; i++)
    begin
      bus(1, SRL_SRC_OFFSET, src_t[i]);
      lvl      <= lvl_t[i];
      sync_sel <= sel_t[i];
      tick(12);
      check(pad_q, exp_t[i]);
      lvl <= 5'h00;
      tick(8);
    end
    // Divider period: time between two sets, short pin reset between
    bus(1, SRL_SRC_OFFSET, 8'h48);
    for (int c = 2; c < 8; c++)
    begin
      lvl <= 5'h10;
      bus(1, SRL_CTRL_OFFSET, {1'b1, c[2:0], 4'hc});
      tick(8);
      check(pad_q, 1'b0);
      lvl <= 5'h00;
      wait_q(1'b1);
      n = 0;
      lvl <= 5'h10;
      tick(2);
      lvl <= 5'h00;
      wait_q(1'b0);
      wait_q(1'b1);
      check(n, 32'd1 << (c + 2));
    end
    results();
  end

  // Watchdog far beyond the expected run length
  initial
  begin
    #100000;
    num_errors++;
    results();
  end
endmodule

`default_nettype wire
